//--- sps_pkg.sv
// Contract
// R01 - Decode write-to-target code per memory type, port
// R02 - Bit tables need byte-aligned address, length; not checked, decode uses only type and port
// R03 - String write sends register bytes verbatim
// R04 - Far terminal matches port serial settings
// R05 - String length counts registers, 2 to 128
// R06 - Byte count first register, data follows
// R07 - Timeout after 10000/rate plus turn-around delay
// R08 - Write-then-read starts read with no gap
// R09 - Write-then-read parameter word layout fixed
// R10 - Forced output point ends string read
// R11 - Count register tracks received characters
// R12 - Read completes when reserved registers full
// R13 - Odd count read needs program termination
// R14 - Low byte first, high byte second
`default_nettype none
package sps_pkg;
	// ------------------------------------------------------------
	// Command codes (hex values of the command word)
	// ------------------------------------------------------------
	localparam logic [15:0] SPS_WR_BASE_P1 = 16'h17DF;
	localparam logic [15:0] SPS_WR_BASE_P2 = 16'h1843;
	localparam logic [15:0] SPS_WR_LAST_P1 = 16'h17E5;
	localparam logic [15:0] SPS_WR_LAST_P2 = 16'h1849;
	localparam logic [15:0] SPS_STRW_P1    = 16'h17E6;
	localparam logic [15:0] SPS_STRW_P2    = 16'h184A;
	localparam logic [15:0] SPS_STRR_P1    = 16'h17DC;
	localparam logic [15:0] SPS_STRR_P2    = 16'h1840;
	localparam logic [15:0] SPS_WTR_P1     = 16'h17F0;
	localparam logic [15:0] SPS_WTR_P2     = 16'h1854;
	// ------------------------------------------------------------
	// Limits and timing
	// ------------------------------------------------------------
	localparam logic [15:0] SPS_LEN_MIN    = 16'h0002;
	localparam logic [15:0] SPS_LEN_MAX    = 16'h0080;
	localparam logic [7:0]  SPS_BYTE_MAX   = 8'hFE;
	localparam int          SPS_TO_NUM     = 10000;
	localparam int          SPS_CLK_HZ     = 250000000;
	localparam int          SPS_TICK_NS    = 1000000;
	localparam int          SPS_CLK_PER_MS = SPS_CLK_HZ / 1000;
	// Word index of parameter block entries
	localparam logic [2:0]  SPS_W_CMD = 3'h0;
	localparam logic [2:0]  SPS_W_P1  = 3'h1;
	localparam logic [2:0]  SPS_W_P2  = 3'h2;
	localparam logic [2:0]  SPS_W_P3  = 3'h3;
	localparam logic [2:0]  SPS_W_P4  = 3'h4;
	localparam logic [2:0]  SPS_W_P5  = 3'h5;
	// Error codes
	localparam logic [1:0]  SPS_ERR_NONE = 2'h0;
	localparam logic [1:0]  SPS_ERR_CMD  = 2'h1;
	localparam logic [1:0]  SPS_ERR_LEN  = 2'h2;
	localparam logic [1:0]  SPS_ERR_TO   = 2'h3;

	typedef enum logic [1:0] {
		SPS_MEM_IDLE,
		SPS_MEM_RD,
		SPS_MEM_WR
	} sps_memop_e;
endpackage : sps_pkg
`default_nettype wire

//--- sps_mem_if.sv
`default_nettype none
// Memory request channel between sequencer and memory port
interface sps_mem_if;
	import sps_pkg::*;
	sps_memop_e  op;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        done;
	modport seq (output op, output addr, output wdata, input rdata, input done);
	modport port (input op, input addr, input wdata, output rdata, output done);
endinterface : sps_mem_if
`default_nettype wire

//--- sps_mem_port.sv
`default_nettype none
// Registers CPU memory handshake: one request in flight
module sps_mem_port
	import sps_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	sps_mem_if.port          req,
	output var  logic        mem_rd_out,
	output var  logic        mem_wr_out,
	output var  logic [15:0] mem_addr_out,
	output var  logic [15:0] mem_wdata_out,
	input  wire logic [15:0] mem_rdata_in,
	input  wire logic        mem_ack_in
);
	typedef struct packed {
		logic        busy;
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        done;
	} sps_mp_s;
	sps_mp_s st_q, st_d;

	// ------------------------------------------------------------
	// Issue and wait for acknowledge
	// ------------------------------------------------------------
	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (!st_q.busy && req.op != SPS_MEM_IDLE && !st_q.done) begin
			st_d.busy  = 1'b1;
			st_d.rd    = (req.op == SPS_MEM_RD);
			st_d.wr    = (req.op == SPS_MEM_WR);
			st_d.addr  = req.addr;
			st_d.wdata = req.wdata;
		end else if (st_q.busy && mem_ack_in) begin
			st_d.busy  = 1'b0;
			st_d.rd    = 1'b0;
			st_d.wr    = 1'b0;
			st_d.rdata = mem_rdata_in;
			st_d.done  = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			st_q <= '0;
		else if (ce_in)
			st_q <= st_d;
	end

	assign req.rdata     = st_q.rdata;
	assign req.done      = st_q.done;
	assign mem_rd_out    = st_q.rd;
	assign mem_wr_out    = st_q.wr;
	assign mem_addr_out  = st_q.addr;
	assign mem_wdata_out = st_q.wdata;
endmodule : sps_mem_port
`default_nettype wire

//--- sps_string_cmd.sv
`default_nettype none
// String and write-to-target command executor
module sps_string_cmd
	import sps_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        cmd_start_in,
	input  wire logic [15:0] cmd_word_in [6],
	input  wire logic [15:0] to_limit_ms_in,
	input  wire logic        term_point_in,
	output var  logic        busy_out,
	output var  logic        done_out,
	output var  logic [1:0]  err_out,
	output var  logic        port_sel_out,
	output var  logic        tgt_req_out,
	output var  logic [2:0]  tgt_mem_type_out,
	input  wire logic        tgt_done_in,
	output var  logic        tx_valid_out,
	output var  logic [7:0]  tx_data_out,
	input  wire logic        tx_ready_in,
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_data_in,
	output var  logic        mem_rd_out,
	output var  logic        mem_wr_out,
	output var  logic [15:0] mem_addr_out,
	output var  logic [15:0] mem_wdata_out,
	input  wire logic [15:0] mem_rdata_in,
	input  wire logic        mem_ack_in
);
	typedef enum logic [3:0] {
		S_IDLE, S_TGT, S_WCNT, S_WDAT, S_TX, S_RINIT, S_RWAIT, S_RSTO, S_RCNT, S_DONE
	} sps_st_e;

	typedef struct packed {
		sps_st_e     st;
		logic        busy;
		logic        done;
		logic [1:0]  err;
		logic        port;
		logic        wtr;
		logic        tgt_req;
		logic [2:0]  mtype;
		logic [15:0] waddr;
		logic [7:0]  wcnt;
		logic [7:0]  widx;
		logic [15:0] wword;
		logic        tx_v;
		logic [7:0]  tx_d;
		logic [15:0] raddr;
		logic [7:0]  rmax;
		logic [7:0]  rcnt;
		logic [15:0] rword;
		logic [15:0] ms;
		logic [27:0] tick;
	} sps_s;
	sps_s q, d;

	sps_memop_e  m_op;
	logic [15:0] m_addr;
	logic [15:0] m_wdata;
	sps_mem_if   mif ();
	logic [15:0] c;
	logic [15:0] wlen;
	logic [15:0] rlen;

	assign mif.op    = m_op;
	assign mif.addr  = m_addr;
	assign mif.wdata = m_wdata;
	assign c         = cmd_word_in[SPS_W_CMD];

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		d       = q;
		d.done  = 1'b0;
		m_op    = SPS_MEM_IDLE;
		m_addr  = 16'h0000;
		m_wdata = 16'h0000;
		wlen    = 16'h0000;
		rlen    = 16'h0000;
		case (q.st)
			S_IDLE: begin
				if (cmd_start_in) begin
					d.busy = 1'b1;
					d.err  = SPS_ERR_NONE;
					d.wtr  = (c == SPS_WTR_P1) || (c == SPS_WTR_P2);
					d.port = (c >= SPS_STRR_P2);
					// R09 word layout
					wlen    = cmd_word_in[SPS_W_P4];
					d.waddr = cmd_word_in[SPS_W_P5];
					rlen    = d.wtr ? cmd_word_in[SPS_W_P1] : cmd_word_in[SPS_W_P4];
					d.raddr = d.wtr ? cmd_word_in[SPS_W_P2] : cmd_word_in[SPS_W_P5];
					d.rmax  = 8'((rlen - 16'h0001) << 1);
					d.rcnt  = 8'h00;
					// R01 write-to-target decode
					if ((c >= SPS_WR_BASE_P1 && c <= SPS_WR_LAST_P1) ||
						(c >= SPS_WR_BASE_P2 && c <= SPS_WR_LAST_P2)) begin
						d.mtype   = 3'(c - (d.port ? SPS_WR_BASE_P2 : SPS_WR_BASE_P1));
						d.tgt_req = 1'b1;
						d.st      = S_TGT;
					end else if (c == SPS_STRW_P1 || c == SPS_STRW_P2 || d.wtr) begin
						// R05 length check
						if (wlen < SPS_LEN_MIN || wlen > SPS_LEN_MAX ||
							(d.wtr && (rlen < SPS_LEN_MIN || rlen > SPS_LEN_MAX))) begin
							d.err = SPS_ERR_LEN;
							d.st  = S_DONE;
						end else
							d.st = S_WCNT;
					end else if (c == SPS_STRR_P1 || c == SPS_STRR_P2) begin
						if (rlen < SPS_LEN_MIN || rlen > SPS_LEN_MAX) begin
							d.err = SPS_ERR_LEN;
							d.st  = S_DONE;
						end else
							d.st = S_RINIT;
					end else begin
						d.err = SPS_ERR_CMD;
						d.st  = S_DONE;
					end
				end
			end
			S_TGT: begin
				if (tgt_done_in) begin
					d.tgt_req = 1'b0;
					d.st      = S_DONE;
				end
			end
			S_WCNT: begin
				// R06 byte count from source register
				m_op   = SPS_MEM_RD;
				m_addr = q.waddr;
				if (mif.done) begin
					d.wcnt  = (mif.rdata > {8'h00, SPS_BYTE_MAX}) ? SPS_BYTE_MAX : mif.rdata[7:0];
					d.widx  = 8'h00;
					d.ms    = 16'h0000;
					d.tick  = 28'h0000000;
					d.waddr = q.waddr + 16'h0001;
					d.st    = (mif.rdata == 16'h0000) ? (q.wtr ? S_RINIT : S_DONE) : S_WDAT;
				end
			end
			S_WDAT: begin
				m_op   = SPS_MEM_RD;
				m_addr = q.waddr;
				if (mif.done) begin
					d.wword = mif.rdata;
					// R14 low byte goes out first
					d.tx_d  = mif.rdata[7:0];
					d.tx_v  = 1'b1;
					d.st    = S_TX;
				end
			end
			S_TX: begin
				// R03 verbatim byte stream
				if (q.tx_v && tx_ready_in) begin
					d.tx_v = 1'b0;
					d.widx = q.widx + 8'h01;
					if (q.widx + 8'h01 == q.wcnt)
						// R08 read follows at once
						d.st = q.wtr ? S_RINIT : S_DONE;
					else if (q.widx[0] == 1'b0) begin
						d.tx_d = q.wword[15:8];
						d.tx_v = 1'b1;
					end else begin
						d.waddr = q.waddr + 16'h0001;
						d.st    = S_WDAT;
					end
				end
			end
			S_RINIT: begin
				d.rcnt = 8'h00;
				d.st   = S_RCNT;
			end
			S_RWAIT: begin
				// R10 forced point ends read
				if (term_point_in)
					d.st = S_DONE;
				else if (rx_valid_in) begin
					// R14 first char in low byte
					if (q.rcnt[0] == 1'b0)
						d.rword = {8'h00, rx_data_in};
					else
						d.rword = {rx_data_in, q.rword[7:0]};
					d.rcnt = q.rcnt + 8'h01;
					d.st   = S_RSTO;
				end
			end
			S_RSTO: begin
				m_op    = SPS_MEM_WR;
				m_addr  = q.raddr + 16'h0001 + {9'h000, q.rcnt[7:1] - {6'h00, ~q.rcnt[0]}};
				m_wdata = q.rword;
				if (mif.done)
					d.st = S_RCNT;
			end
			S_RCNT: begin
				// R11 running count register
				m_op    = SPS_MEM_WR;
				m_addr  = q.raddr;
				m_wdata = {8'h00, q.rcnt};
				if (mif.done)
					// R12 stop when buffer is full
					d.st = (q.rcnt >= q.rmax) ? S_DONE : S_RWAIT;
			end
			S_DONE: begin
				d.busy = 1'b0;
				d.done = 1'b1;
				d.tx_v = 1'b0;
				d.st   = S_IDLE;
			end
			default: d.st = S_IDLE;
		endcase
		// R07 transmit time limit
		if (q.st == S_WDAT || q.st == S_TX) begin
			if (q.tick == 28'(SPS_CLK_PER_MS - 1)) begin
				d.tick = 28'h0000000;
				d.ms   = q.ms + 16'h0001;
			end else
				d.tick = q.tick + 28'h0000001;
			if (q.ms >= to_limit_ms_in) begin
				d.err  = SPS_ERR_TO;
				d.tx_v = 1'b0;
				d.st   = S_DONE;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in)
			q <= '0;
		else if (ce_in)
			q <= d;
	end

	// ------------------------------------------------------------
	// Memory port
	// ------------------------------------------------------------
	sps_mem_port sps_mem_port_inst (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.ce_in         (ce_in),
		.req           (mif.port),
		.mem_rd_out    (mem_rd_out),
		.mem_wr_out    (mem_wr_out),
		.mem_addr_out  (mem_addr_out),
		.mem_wdata_out (mem_wdata_out),
		.mem_rdata_in  (mem_rdata_in),
		.mem_ack_in    (mem_ack_in)
	);

	assign busy_out         = q.busy;
	assign done_out         = q.done;
	assign err_out          = q.err;
	assign port_sel_out     = q.port;
	assign tgt_req_out      = q.tgt_req;
	assign tgt_mem_type_out = q.mtype;
	assign tx_valid_out     = q.tx_v;
	assign tx_data_out      = q.tx_d;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_len_reject;
		@(posedge clk_in) disable iff (rst_in)
		(q.st == S_IDLE && cmd_start_in && ce_in && (c == SPS_STRW_P1) &&
		 (cmd_word_in[SPS_W_P4] > SPS_LEN_MAX)) |=> (q.err == SPS_ERR_LEN);
	endproperty
	a_len_reject: assert property (p_len_reject) else $error("bad length accepted"); // R05

	property p_term_ends;
		@(posedge clk_in) disable iff (rst_in)
		(q.st == S_RWAIT && term_point_in && ce_in) |=> (q.st == S_DONE) ##1 done_out;
	endproperty
	a_term_ends: assert property (p_term_ends) else $error("terminate point ignored"); // R10

	property p_tx_cap;
		@(posedge clk_in) disable iff (rst_in)
		tx_valid_out |-> (q.widx < q.wcnt) && (q.wcnt <= SPS_BYTE_MAX);
	endproperty
	a_tx_cap: assert property (p_tx_cap) else $error("byte limit exceeded"); // R06

	property p_rd_len_reject;
		@(posedge clk_in) disable iff (rst_in) (q.st == S_IDLE && cmd_start_in && ce_in && c == SPS_STRR_P1 &&
		 cmd_word_in[SPS_W_P4] < SPS_LEN_MIN) |=> (q.err == SPS_ERR_LEN);
	endproperty
	a_rd_len_reject: assert property (p_rd_len_reject) else $error("short read length accepted"); // R05
	property p_user_logic_code;
		@(posedge clk_in) disable iff (rst_in) (q.st == S_IDLE && cmd_start_in && ce_in && c == SPS_WR_LAST_P2)
		 |=> (tgt_req_out && port_sel_out && tgt_mem_type_out == 3'(SPS_WR_LAST_P2 - SPS_WR_BASE_P2));
	endproperty
	a_user_logic_code: assert property (p_user_logic_code) else $error("user logic target misdecoded"); // R01
	property p_read_follows;
		@(posedge clk_in) disable iff (rst_in) (tx_valid_out && tx_ready_in && ce_in &&
		 q.wtr && q.widx + 8'h01 == q.wcnt) |-> ##[1:4] (mem_wr_out && mem_addr_out == q.raddr);
	endproperty
	a_read_follows: assert property (p_read_follows) else $error("read did not follow write"); // R08
endmodule : sps_string_cmd
`default_nettype wire

//--- sps_term_model.sv
`default_nettype none
// Serial terminal on the far side of the port
module sps_term_model
	import sps_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       slow_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output var  logic       tx_ready_out,
	output var  logic       rx_valid_out,
	output var  logic [7:0] rx_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got_q [$];
	logic       ph_q = 1'b0;
	initial begin
		tx_ready_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_data_out  = 8'h00;
	end
	// same port settings: bytes are taken raw, slow mode stalls every other cycle
	always @(posedge clk_in) begin
		ph_q <= ~ph_q;
		tx_ready_out <= ~slow_in | ph_q;
		if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
	end
	// One received character; line shows junk once released
	task send(input logic [7:0] b);
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_data_out  <= b;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_data_out  <= ~b;
		repeat (10) @(posedge clk_in);
	endtask : send
endmodule : sps_term_model
`default_nettype wire

//--- serial_port_write_string_cmds_tb.sv
`default_nettype none
module serial_port_write_string_cmds_tb
	import sps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, rst_in, cmd_start, term_pt, busy, done, port_sel, tgt_req, tgt_done, slow;
	logic        tx_valid, tx_ready, rx_valid, mem_rd, mem_wr, mem_ack;
	logic [1:0]  err;
	logic [2:0]  tgt_type, seen_type;
	logic [7:0]  tx_data, rx_data;
	logic [15:0] cmd_word [6];
	logic [15:0] mem_addr, mem_wdata, mem_rdata, to_lim;
	logic [15:0] mem [0:255];
	int          fail_count, checks_done, cyc;
	sps_string_cmd sps_string_cmd_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .cmd_start_in(cmd_start),
		.cmd_word_in(cmd_word), .to_limit_ms_in(to_lim), .term_point_in(term_pt), .busy_out(busy),
		.done_out(done), .err_out(err), .port_sel_out(port_sel), .tgt_req_out(tgt_req),
		.tgt_mem_type_out(tgt_type), .tgt_done_in(tgt_done), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
		.tx_ready_in(tx_ready), .rx_valid_in(rx_valid), .rx_data_in(rx_data), .mem_rd_out(mem_rd),
		.mem_wr_out(mem_wr), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
		.mem_ack_in(mem_ack));
	sps_term_model sps_term_model_inst (.clk_in(clk_in), .slow_in(slow), .tx_valid_in(tx_valid),
		.tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data));
	initial begin
		clk_in = 1'b0;
	end
	always #2 clk_in = ~clk_in;
	// CPU memory and target engine: one-cycle ack, read data scrambled off ack
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if ((mem_rd || mem_wr) && !mem_ack) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[7:0]];
			if (mem_wr) mem[mem_addr[7:0]] <= mem_wdata;
		end
		tgt_done <= tgt_req & ~tgt_done;
		if (tgt_req) seen_type <= tgt_type;
		if (cyc == 60000) begin
			fail_count++;
			summarize();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Issue one parameter block and wait for completion
	task cmd(input logic [15:0] c, w1, w2, w3, w4, w5, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk_in);
		cmd_word <= '{c, w1, w2, w3, w4, w5};
		cmd_start <= 1'b1;
		@(posedge clk_in);
		cmd_start <= 1'b0;
		#1;
		while (done !== 1'b1 && n < 5000) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk(16'(done), 16'h0001);
		chk(16'(err), 16'(e));
	endtask : cmd
	// Bytes seen on the line, first byte in the low bits of w
	task chk_tx(input logic [31:0] w, input int n);
		for (int i = 0; i < n; i++) chk(16'(sps_term_model_inst.got_q[i]), 16'(w[8*i+:8]));
		chk(16'(sps_term_model_inst.got_q.size()), 16'(n));
		sps_term_model_inst.got_q.delete();
	endtask : chk_tx
	task summarize();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	initial begin
		{rst_in, cmd_start, term_pt, slow, tgt_done, mem_ack} = 6'h20;
		{fail_count, checks_done, cyc} = '0;
		cmd_word = '{default: 16'h0000};
		mem = '{default: 16'h0000};
		mem_rdata = 16'h0000;
		to_lim = 16'h0001;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		// aligned address and length; every memory type on both ports
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7; i++) begin
				cmd((p ? SPS_WR_BASE_P2 : SPS_WR_BASE_P1) + 16'(i), 16'h000A, 16'(i), 16'h0008, 16'h0010, 16'h0001,
					SPS_ERR_NONE);
				chk(16'(seen_type), 16'(i));
				chk(16'(port_sel), 16'(p));
			end
		end
		$display("test write_to_target done");
		{mem[100], mem[101], mem[102]} = {16'h0004, 16'h5453, 16'h504F};
		cmd(SPS_STRW_P1, 0, 0, 0, 16'h0003, 16'h0064, SPS_ERR_NONE);
		chk_tx(32'h504F5453, 4);
		slow <= 1'b1;
		mem[100] = 16'h0002;
		cmd(SPS_STRW_P2, 0, 0, 0, 16'h0002, 16'h0064, SPS_ERR_NONE);
		chk_tx(32'h00005453, 2);
		chk(16'(port_sel), 16'h0001);
		slow <= 1'b0;
		// Zero limit: the transmit timer expires before any byte leaves
		to_lim <= 16'h0000;
		cmd(SPS_STRW_P1, 0, 0, 0, 16'h0003, 16'h0064, SPS_ERR_TO);
		to_lim <= 16'h0001;
		cmd(SPS_STRR_P1, 0, 0, 16'h0400, 16'h0001, 16'h0096, SPS_ERR_LEN);
		cmd(SPS_STRW_P1, 0, 0, 0, 16'h0001, 16'h0064, SPS_ERR_LEN);
		cmd(SPS_STRW_P1, 0, 0, 0, 16'h0081, 16'h0064, SPS_ERR_LEN);
		cmd(16'h1234, 0, 0, 0, 16'h0003, 16'h0064, SPS_ERR_CMD);
		chk_tx(32'h0, 0);
		$display("test string_write done");
		fork
			cmd(SPS_STRR_P2, 0, 0, 16'h0400, 16'h0003, 16'h0096, SPS_ERR_NONE);
			begin
				repeat (30) @(posedge clk_in);
				for (int i = 0; i < 4; i++) sps_term_model_inst.send(8'(32'h53544F50 >> (8 * (3 - i))));
			end
		join
		chk(mem[150], 16'h0004);
		chk(mem[151], 16'h5453);
		chk(mem[152], 16'h504F);
		// odd count: program watches the count and forces the point
		fork
			cmd(SPS_STRR_P1, 0, 0, 16'h0400, 16'h0003, 16'h0096, SPS_ERR_NONE);
			begin
				repeat (30) @(posedge clk_in);
				for (int i = 0; i < 3; i++) sps_term_model_inst.send(8'h41 + 8'(i));
				repeat (40) @(posedge clk_in);
				chk(16'(busy), 16'h0001);
				chk(mem[150], 16'h0003);
				term_pt <= 1'b1;
			end
		join
		term_pt <= 1'b0;
		chk(mem[151], 16'h4241);
		$display("test string_read done");
		{mem[100], mem[150]} = {16'h0004, 16'hFFFF};
		fork
			cmd(SPS_WTR_P1, 16'h0002, 16'h0096, 16'h0400, 16'h0003, 16'h0064, SPS_ERR_NONE);
			begin
				repeat (100) @(posedge clk_in);
				chk(mem[150], 16'h0000);
				sps_term_model_inst.send(8'h47);
				sps_term_model_inst.send(8'h4F);
			end
		join
		chk_tx(32'h504F5453, 4);
		chk(mem[150], 16'h0002);
		chk(mem[151], 16'h4F47);
		$display("test write_then_read done");
		summarize();
	end
endmodule : serial_port_write_string_cmds_tb
`default_nettype wire
